// ==== logic/rsd_pkg.sv ====
// rotary switch decoder: shared constants, types and decode functions
// assumes a single 100 MHz clock and a byte-wide register port
package rsd_pkg;

  // ******************************************************
  // register map
  // ******************************************************
  localparam logic [7:0] ADDR_CONTROL = 8'h70;
  localparam logic [7:0] ADDR_BUFFER  = 8'h72;
  localparam logic [7:0] CONTROL_RST  = 8'h00;
  localparam logic [7:0] BUFFER_RST   = 8'h00;
  localparam int         RUN_BIT      = 7;
  localparam int         TYPE_BIT     = 7;
  localparam int         CNT_W        = 7;
  localparam logic [6:0] CNT_MAX      = 7'h7f;
  localparam logic [6:0] CNT_ONE      = 7'h01;
  localparam logic       DIR_UP       = 1'b0;
  localparam logic       DIR_DOWN     = 1'b1;

  // ******************************************************
  // contacts and timing
  // ******************************************************
  localparam int CON_A = 0;
  localparam int CON_B = 1;
  localparam int CON_C = 2;
  localparam int CLK_PERIOD_PS = 10000;
  localparam int SETTLE_NS     = 100;
  localparam int SETTLE_W      = 4;
  localparam logic [3:0] SETTLE_CYC =
    4'((SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DRIVE_A,
    ST_DRIVE_B,
    ST_DRIVE_C
  } rsd_state_t;

  typedef struct packed {
    logic       hit;
    logic       dir;
    rsd_state_t nxt;
  } rsd_step_t;

  // one-hot mask of the contact driven in a scan state; zero in idle
  function automatic logic [2:0] rsd_drive_mask(input rsd_state_t s);
    logic [2:0] m;
    m = 3'h0;
    unique case (s)
      ST_IDLE:    m = 3'h0;
      ST_DRIVE_A: m = 3'h1;
      ST_DRIVE_B: m = 3'h2;
      ST_DRIVE_C: m = 3'h4;
    endcase
    return m;
  endfunction

  // a step needs exactly one input contact low; both low is ignored
  function automatic rsd_step_t rsd_step(input rsd_state_t s,
                                         input logic [2:0] lvl);
    rsd_step_t r;
    r = '{hit: 1'b0, dir: DIR_UP, nxt: s};
    unique case (s)
      ST_IDLE: r.hit = 1'b0;
      ST_DRIVE_A: begin
        if (!lvl[CON_C] && lvl[CON_B]) begin
          r = '{hit: 1'b1, dir: DIR_UP, nxt: ST_DRIVE_B};
        end else if (!lvl[CON_B] && lvl[CON_C]) begin
          r = '{hit: 1'b1, dir: DIR_DOWN, nxt: ST_DRIVE_C};
        end
      end
      ST_DRIVE_B: begin
        if (!lvl[CON_A] && lvl[CON_C]) begin
          r = '{hit: 1'b1, dir: DIR_DOWN, nxt: ST_DRIVE_C};
        end else if (!lvl[CON_C] && lvl[CON_A]) begin
          r = '{hit: 1'b1, dir: DIR_UP, nxt: ST_DRIVE_A};
        end
      end
      ST_DRIVE_C: begin
        if (!lvl[CON_A] && lvl[CON_B]) begin
          r = '{hit: 1'b1, dir: DIR_UP, nxt: ST_DRIVE_B};
        end else if (!lvl[CON_B] && lvl[CON_A]) begin
          r = '{hit: 1'b1, dir: DIR_DOWN, nxt: ST_DRIVE_A};
        end
      end
    endcase
    return r;
  endfunction

endpackage

// ==== logic/rsd_if.sv ====
// rotary switch decoder: filtered contact levels from sampler to core
// assumes both ends run on mclk
`timescale 1ns/1ps
interface rsd_if;
  logic [2:0] lvl;
  modport src (output lvl);
  modport dst (input lvl);
endinterface

// ==== logic/rsd_sampler.sv ====
// rotary switch decoder: contact pin synchroniser and agreement filter
// assumes contact pins are asynchronous to mclk
`timescale 1ns/1ps
module rsd_sampler
  import rsd_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic [2:0] contact_in,
  rsd_if.src              lvl_out
);

  // ******************************************************
  // state
  // ******************************************************
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] lvl;
  } rsd_smp_t;

  rsd_smp_t q;
  rsd_smp_t next_q;

  always_comb begin
    next_q    = q;
    next_q.s1 = contact_in;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    // s1 feeds only s2; a level counts once s2 and s3 agree
    for (int i = 0; i < 3; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        next_q.lvl[i] = q.s3[i];
      end
    end
  end

  // idle contacts float high through their pull-ups
  always_ff @(posedge mclk) begin
    if (srst) begin
      q <= '{s1: 3'h7, s2: 3'h7, s3: 3'h7, lvl: 3'h7};
    end else begin
      q <= next_q;
    end
  end

  assign lvl_out.lvl = q.lvl;

endmodule

// ==== logic/rsd_top.sv ====
// rotary switch decoder: scan state machine and movement buffer
// assumes byte register port from the host interface, contacts on pins
//
// Summary of operation
// - buffer bit 7 gives direction, 1 down
// - buffer bits 6..0 count movements, up to 127
// - correct state reached within two rotations, continuous
// - interrupt on recorded movement; host waits
// - one contact driven, two pulled-up inputs
// - states 1 to 3 step per short seen
// - control bit 7 runs or stops, resets zero
`timescale 1ns/1ps
module rsd_top
  import rsd_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            movement_irq,
  input  wire logic [2:0] contact_in,
  output logic      [2:0] contact_out,
  output logic      [2:0] contact_oe,
  output logic      [2:0] pullup_select
);

  // ******************************************************
  // contact sampling
  // ******************************************************
  rsd_if lvl_bus ();

  rsd_sampler u_sampler (
    .mclk       (mclk),
    .srst       (srst),
    .contact_in (contact_in),
    .lvl_out    (lvl_bus)
  );

  // ******************************************************
  // state
  // ******************************************************
  typedef struct packed {
    logic                run_decoder;
    rsd_state_t          state;
    logic [SETTLE_W-1:0] settle;
    logic                buf_type;
    logic [CNT_W-1:0]    buf_cnt;
    logic                irq;
    logic [7:0]          rdata;
    logic [2:0]          out;
    logic [2:0]          oe;
    logic [2:0]          pull;
  } rsd_core_t;

  rsd_core_t q;
  rsd_core_t next_q;
  rsd_step_t stp;
  logic      fire;
  logic      buf_read;

  assign stp      = rsd_step(q.state, lvl_bus.lvl);
  assign buf_read = reg_rd && (reg_addr == ADDR_BUFFER);
  // settle wait covers drive change plus sampler latency
  assign fire     = q.run_decoder && (q.state != ST_IDLE)
                    && (q.settle == '0) && stp.hit;

  always_comb begin
    next_q = q;
    if (reg_wr && (reg_addr == ADDR_CONTROL)) begin
      next_q.run_decoder = reg_wdata[RUN_BIT];
    end
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CONTROL: next_q.rdata = {q.run_decoder, 7'h00};
        ADDR_BUFFER:  next_q.rdata = {q.buf_type, q.buf_cnt};
        default:      next_q.rdata = 8'h00;
      endcase
    end
    // read empties the buffer; a movement in the same cycle still counts
    if (buf_read) begin
      next_q.buf_type = DIR_UP;
      next_q.buf_cnt  = '0;
      next_q.irq      = 1'b0;
    end
    if (!q.run_decoder) begin
      next_q.state  = ST_IDLE;
      next_q.settle = '0;
    end else if (q.state == ST_IDLE) begin
      // any start state self-corrects on the first short seen
      next_q.state  = ST_DRIVE_A;
      next_q.settle = SETTLE_CYC;
    end else if (q.settle != '0) begin
      next_q.settle = q.settle - 4'h1;
    end else if (stp.hit) begin
      next_q.state  = stp.nxt;
      next_q.settle = SETTLE_CYC;
      // opposite direction restarts the count: newest motion wins
      if ((next_q.buf_cnt == '0) || (next_q.buf_type == stp.dir)) begin
        if (next_q.buf_cnt != CNT_MAX) begin
          next_q.buf_cnt = next_q.buf_cnt + CNT_ONE;
        end
      end else begin
        next_q.buf_cnt = CNT_ONE;
      end
      next_q.buf_type = stp.dir;
      next_q.irq      = 1'b1;
    end
    next_q.out  = 3'h0;
    next_q.oe   = rsd_drive_mask(next_q.state);
    next_q.pull = ~next_q.oe;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      q <= '{run_decoder: CONTROL_RST[RUN_BIT], state: ST_IDLE,
             settle: '0, buf_type: BUFFER_RST[TYPE_BIT],
             buf_cnt: BUFFER_RST[CNT_W-1:0], irq: 1'b0,
             rdata: 8'h00, out: 3'h0, oe: 3'h0, pull: 3'h7};
    end else begin
      q <= next_q;
    end
  end

  assign reg_rdata     = q.rdata;
  assign movement_irq  = q.irq;
  assign contact_out   = q.out;
  assign contact_oe    = q.oe;
  assign pullup_select = q.pull;

  // ******************************************************
  // checks
  // ******************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  property p_dir_flag;
    fire |=> (q.buf_type == $past(stp.dir)) && (q.buf_cnt != '0);
  endproperty
  a_dir_flag: assert property (p_dir_flag)
    else $error("direction flag not taken from movement");

  property p_count_step;
    fire && !buf_read && (q.buf_type == stp.dir) && (q.buf_cnt != '0)
      && (q.buf_cnt != CNT_MAX) |=> q.buf_cnt == $past(q.buf_cnt) + CNT_ONE;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("movement count did not advance by one");

  property p_start_state;
    $rose(q.run_decoder) |=> (q.state == ST_DRIVE_A)
      ##1 (q.settle == SETTLE_CYC - 4'h1);
  endproperty
  a_start_state: assert property (p_start_state)
    else $error("decoder did not enter first scan state");

  property p_irq_set;
    fire |=> movement_irq && (q.buf_cnt != '0);
  endproperty
  a_irq_set: assert property (p_irq_set)
    else $error("interrupt missing after movement");

  property p_one_driven;
    (q.state != ST_IDLE) |-> $onehot(contact_oe)
      && (contact_oe == rsd_drive_mask(q.state))
      && (pullup_select == ~contact_oe) && (contact_out == 3'h0);
  endproperty
  a_one_driven: assert property (p_one_driven)
    else $error("contact drive pattern wrong");

  property p_state_a_b;
    fire && (q.state == ST_DRIVE_A) && !lvl_bus.lvl[CON_C]
      |=> (q.state == ST_DRIVE_B) && (q.buf_type == DIR_UP);
  endproperty
  a_state_a_b: assert property (p_state_a_b)
    else $error("state 1 short on C not decoded as up");

  property p_stop;
    !q.run_decoder |=> (q.state == ST_IDLE) && (contact_oe == 3'h0)
      && ($stable(q.buf_cnt) || $past(buf_read));
  endproperty
  a_stop: assert property (p_stop)
    else $error("decoder active while stopped");

  property p_state_c;
    fire && (q.state == ST_DRIVE_C) |=> ($past(lvl_bus.lvl[CON_A])
      ? ((q.state == ST_DRIVE_A) && (q.buf_type == DIR_DOWN))
      : ((q.state == ST_DRIVE_B) && (q.buf_type == DIR_UP)));
  endproperty
  a_state_c: assert property (p_state_c)
    else $error("state 3 step decoded wrongly");

  property p_state_a_c;
    fire && (q.state == ST_DRIVE_A) && !lvl_bus.lvl[CON_B]
      |=> (q.state == ST_DRIVE_C) && (q.buf_type == DIR_DOWN);
  endproperty
  a_state_a_c: assert property (p_state_a_c)
    else $error("state 1 short on B not decoded as down");

  property p_state_b;
    fire && (q.state == ST_DRIVE_B) |=> ($past(lvl_bus.lvl[CON_A])
      ? ((q.state == ST_DRIVE_A) && (q.buf_type == DIR_UP))
      : ((q.state == ST_DRIVE_C) && (q.buf_type == DIR_DOWN)));
  endproperty
  a_state_b: assert property (p_state_b)
    else $error("state 2 step decoded wrongly");

  // count must stick at the ceiling, never wrap to zero
  property p_saturate;
    fire && !buf_read && (q.buf_type == stp.dir) && (q.buf_cnt == CNT_MAX)
      |=> q.buf_cnt == CNT_MAX;
  endproperty
  a_saturate: assert property (p_saturate)
    else $error("movement count wrapped past its ceiling");

  property p_reverse;
    fire && !buf_read && (q.buf_cnt != '0) && (q.buf_type != stp.dir)
      |=> (q.buf_cnt == CNT_ONE) && (q.buf_type == $past(stp.dir));
  endproperty
  a_reverse: assert property (p_reverse)
    else $error("direction change did not restart the count");

  // a read with no movement in the same cycle clears buffer and interrupt
  property p_read_clear;
    buf_read && !fire |=> (q.buf_cnt == '0) && (q.buf_type == DIR_UP)
      && !movement_irq;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("buffer read did not clear buffer and interrupt");

endmodule

// ==== verification/rsd_switch.sv ====
// rotary switch model: three contacts shorted in commanded pairs
// assumes the device drives one contact low and pulls the rest up
`timescale 1ns/1ps
module rsd_switch (
  input  wire logic       mclk,
  input  wire logic [2:0] shorts,
  input  wire logic [2:0] contact_out,
  input  wire logic [2:0] contact_oe,
  input  wire logic [2:0] pullup_select,
  output logic      [2:0] contact_in
);
  // ******************************************************
  // wire levels
  // ******************************************************
  // shorts[0] a-b, [1] b-c, [2] c-a; no chaining through an open pin
  logic flip = 1'b0;

  // an open pin without pull-up wanders so it never reads as a clean level
  always @(posedge mclk) flip <= ~flip;

  function automatic logic lvl(input logic oe, out, s1, oe1, out1,
                               input logic s2, oe2, out2, pu, fl);
    if (oe) return out;
    if (s1 && oe1) return out1;
    if (s2 && oe2) return out2;
    return pu ? 1'b1 : fl;
  endfunction

  always_comb begin
    contact_in[0] = lvl(contact_oe[0], contact_out[0], shorts[0],
      contact_oe[1], contact_out[1], shorts[2], contact_oe[2],
      contact_out[2], pullup_select[0], flip);
    contact_in[1] = lvl(contact_oe[1], contact_out[1], shorts[0],
      contact_oe[0], contact_out[0], shorts[1], contact_oe[2],
      contact_out[2], pullup_select[1], ~flip);
    contact_in[2] = lvl(contact_oe[2], contact_out[2], shorts[1],
      contact_oe[1], contact_out[1], shorts[2], contact_oe[0],
      contact_out[0], pullup_select[2], flip);
  end
endmodule

// ==== verification/rotary_switch_decoder_tb.sv ====
// testbench for the rotary switch decoder: register calls and moves
// assumes rsd_top register port timing and the switch model
`timescale 1ns/1ps
module rotary_switch_decoder_tb;
  import rsd_pkg::*;
  logic       mclk;
  logic       srst;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       movement_irq;
  logic [2:0] contact_in;
  logic [2:0] contact_out;
  logic [2:0] contact_oe;
  logic [2:0] pullup_select;
  logic [2:0] shorts;
  int         n_fail;
  int         compares;
  int         cycles;

  rsd_top i_dut (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .movement_irq(movement_irq),
    .contact_in(contact_in), .contact_out(contact_out),
    .contact_oe(contact_oe), .pullup_select(pullup_select));

  rsd_switch i_switch (.mclk(mclk), .shorts(shorts),
    .contact_out(contact_out), .contact_oe(contact_oe),
    .pullup_select(pullup_select), .contact_in(contact_in));

  // ******************************************************
  // tasks
  // ******************************************************
  task automatic results;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, exp);
  endtask

  task automatic pins(input logic [2:0] oe, input logic irq);
    chk("contact_oe", {5'h0, contact_oe}, {5'h0, oe});
    chk("pullup_select", {5'h0, pullup_select}, {5'h0, ~oe});
    chk("contact_out", {5'h0, contact_out}, 8'h00);
    chk("movement_irq", {7'h0, movement_irq}, {7'h0, irq});
  endtask

  // bounded wait for the drive to move on, then release and let it settle
  task automatic move(input logic [2:0] s, oe, input logic irq);
    logic [2:0] was;
    was = contact_oe;
    @(posedge mclk);
    shorts <= s;
    for (int i = 0; i < 100 && contact_oe === was; i++) @(posedge mclk);
    #1;
    pins(oe, irq);
    @(posedge mclk);
    shorts <= 3'h0;
    repeat (20) @(posedge mclk);
  endtask

  // ******************************************************
  // clock, timeout, sequence
  // ******************************************************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      results;
    end
  end

  initial begin
    n_fail = 0;
    compares = 0;
    cycles = 0;
    srst = 1'b1;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    shorts = 3'h0;
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    #1;
    pins(3'h0, 1'b0);
    rd(ADDR_CONTROL, CONTROL_RST);
    rd(ADDR_BUFFER, BUFFER_RST);
    wr(ADDR_CONTROL, 8'hff);
    rd(ADDR_CONTROL, 8'h80);
    repeat (20) @(posedge mclk);
    #1;
    pins(3'h1, 1'b0);
    move(3'h4, 3'h2, 1'b1);
    move(3'h2, 3'h1, 1'b1);
    move(3'h4, 3'h2, 1'b1);
    rd(ADDR_BUFFER, 8'h03);
    chk("movement_irq", {7'h0, movement_irq}, 8'h00);
    move(3'h1, 3'h4, 1'b1);
    move(3'h2, 3'h1, 1'b1);
    move(3'h1, 3'h4, 1'b1);
    rd(ADDR_BUFFER, 8'h83);
    move(3'h4, 3'h2, 1'b1);
    rd(ADDR_BUFFER, 8'h01);
    move(3'h3, 3'h2, 1'b0);
    // long up run alternates a and b driven, past the count ceiling
    for (int i = 0; i < 128; i++) begin
      if (contact_oe === 3'h2) move(3'h2, 3'h1, 1'b1);
      else move(3'h4, 3'h2, 1'b1);
    end
    rd(ADDR_BUFFER, {DIR_UP, CNT_MAX});
    move(3'h2, 3'h1, 1'b1);
    move(3'h1, 3'h4, 1'b1);
    wr(ADDR_CONTROL, 8'h00);
    repeat (3) @(posedge mclk);
    #1;
    pins(3'h0, 1'b1);
    move(3'h1, 3'h0, 1'b1);
    rd(ADDR_CONTROL, 8'h00);
    rd(ADDR_BUFFER, 8'h81);
    wr(ADDR_BUFFER, 8'h55);
    rd(ADDR_BUFFER, 8'h00);
    rd(8'h71, 8'h00);
    wr(ADDR_CONTROL, 8'h80);
    repeat (20) @(posedge mclk);
    #1;
    pins(3'h1, 1'b0);
    results;
  end
endmodule
